// >>> tb/mgmt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Management host: issues one-cycle read and write strobes on the register port.
module mgmt_host_model (
  // Clock.
  input wire logic clk,
  // Request side.
  output logic [4:0] reg_addr,
  output logic reg_wr_en,
  output logic [15:0] reg_wr_data,
  output logic reg_rd_en,
  // Answer side.
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  // Idle strobes at time zero.
  initial
  begin
    reg_addr = 5'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 16'h0000;
    reg_rd_en = 1'b0;
  end
  // Called just after an edge; the data is inverted once released so stale values never match.
  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    reg_addr = addr;
    reg_wr_data = data;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_wr_data = ~data;
    reg_addr = ~addr;
    // One idle edge keeps the next strobe out of this time step.
    @(posedge clk);
    #1;
  endtask : write_reg
  // The answer stands for one cycle after the taking edge, so it is sampled then.
  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data, output logic vld);
    reg_addr = addr;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    data = reg_rd_data;
    vld = reg_rd_valid;
    reg_addr = ~addr;
    @(posedge clk);
    #1;
  endtask : read_reg
endmodule : mgmt_host_model
`default_nettype wire

// >>> tb/phy_basic_control_register_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the control register through the host model and compares read-back values.
module phy_basic_control_register_tb_top;
  logic clk;
  logic resetn;
  logic [1:0] strap_speed_pin;
  logic strap_neg_enable_pin;
  logic strap_power_down_pin;
  logic link_valid;
  logic [4:0] reg_addr;
  logic reg_wr_en;
  logic [15:0] reg_wr_data;
  logic reg_rd_en;
  logic [15:0] reg_rd_data;
  logic reg_rd_valid;
  logic soft_reset_request;
  logic [1:0] speed_select;
  logic mac_tx_allow;
  int error_cnt = 0;
  int samples_checked = 0;
  // Write data and read-back pairs; 0x2040 carries the reserved speed code.
  logic [15:0] wtab [11] = '{16'h4000, 16'h2000, 16'h2040, 16'h0040, 16'h0000, 16'h1000,
    16'h0800, 16'h0400, 16'h0100, 16'h0080, 16'h003F};
  logic [15:0] etab [11] = '{16'h4000, 16'h2000, 16'h2000, 16'h0040, 16'h0000, 16'h1000,
    16'h0800, 16'h0400, 16'h0100, 16'h0080, 16'h0000};
  // The host model owns the register strobes.
  mgmt_host_model mgmt_host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid));
  phy_basic_control_register phy_basic_control_register_inst (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .strap_speed_pin(strap_speed_pin), .strap_neg_enable_pin(strap_neg_enable_pin),
    .strap_power_down_pin(strap_power_down_pin), .link_valid(link_valid),
    .soft_reset_request(soft_reset_request), .loopback_enable(), .speed_select(speed_select),
    .negotiation_enable(), .soft_power_down(), .mac_isolate(), .mac_pin_oe_n(),
    .negotiation_restart(), .full_duplex_select(), .collision_signal_test(),
    .one_way_transmit_enable(), .mac_tx_allow(mac_tx_allow));
  // Free-running 25 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Reads a register and compares both the valid pulse and the data.
  task automatic read_check(input logic [4:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    mgmt_host_model_inst.read_reg(addr, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask : read_check
  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Cuts a hang short; the tests need well under a thousand cycles.
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence; straps select 100 Mbps, no negotiation, power-down.
  initial
  begin
    resetn = 1'b0;
    link_valid = 1'b0;
    strap_speed_pin = 2'h1;
    strap_neg_enable_pin = 1'b0;
    strap_power_down_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    read_check(5'h00, 16'h2800);
    check({14'h0000, speed_select}, {14'h0000, phy_ctrl_pkg::SPEED_100});
    for (int i = 0; i < 11; i++)
    begin
      mgmt_host_model_inst.write_reg(5'h00, wtab[i]);
      read_check(5'h00, etab[i]);
    end
    check({15'h0000, mac_tx_allow}, 16'h0000);
    link_valid = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, mac_tx_allow}, 16'h0001);
    // An unmapped write must leave the control word alone.
    mgmt_host_model_inst.write_reg(5'h01, 16'h4000);
    read_check(5'h01, 16'h0000);
    read_check(5'h00, 16'h0000);
    // Restart reads back set once, then clears itself.
    mgmt_host_model_inst.write_reg(5'h00, 16'h0200);
    read_check(5'h00, 16'h0200);
    @(posedge clk);
    #1;
    read_check(5'h00, 16'h0000);
    // Soft reset blocks writes while it runs, then reloads the strap defaults.
    mgmt_host_model_inst.write_reg(5'h00, 16'h8400);
    mgmt_host_model_inst.write_reg(5'h00, 16'h4000);
    read_check(5'h00, 16'h8400);
    for (int i = 0; i < 40 && soft_reset_request !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    check({15'h0000, soft_reset_request}, 16'h0000);
    read_check(5'h00, 16'h2800);
    tally_and_finish();
  end
endmodule : phy_basic_control_register_tb_top
`default_nettype wire

// >>> tb/phy_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Checks field and timing relations at the ports of the control register.
module phy_ctrl_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid,
  // Link state and controls.
  input wire logic link_valid,
  input wire logic soft_reset_request,
  input wire logic loopback_enable,
  input wire logic [1:0] speed_select,
  input wire logic negotiation_enable,
  input wire logic soft_power_down,
  input wire logic mac_isolate,
  input wire logic mac_pin_oe_n,
  input wire logic negotiation_restart,
  input wire logic full_duplex_select,
  input wire logic collision_signal_test,
  input wire logic one_way_transmit_enable,
  input wire logic mac_tx_allow
);
  // Edges since reset release; the strap load lands on the fourth and wins over a write.
  logic [2:0] since_release;
  always_ff @(posedge clk)
  begin
    if (!resetn)
      since_release <= 3'h0;
    else if (since_release != 3'h7)
      since_release <= since_release + 3'h1;
  end
  // A write that the core accepts: mapped address, no soft reset, not the strap load edge.
  logic wr_ok;
  assign wr_ok = reg_wr_en && (reg_addr == phy_ctrl_pkg::CTRL_ADDR) && !soft_reset_request
    && since_release != 3'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_loopback_follows_write: assert property (
    wr_ok |=> loopback_enable == $past(reg_wr_data[14])) else $error("loopback wrong");
  a_isolate_follows_write: assert property (
    wr_ok |=> mac_isolate == $past(reg_wr_data[10]) && mac_pin_oe_n == $past(reg_wr_data[10]))
    else $error("isolate wrong");
  a_duplex_collision_signal_test_write: assert property (
    wr_ok |=> full_duplex_select == $past(reg_wr_data[8])
      && collision_signal_test == $past(reg_wr_data[7])) else $error("duplex or test wrong");
  a_restart_pulse_due: assert property (
    wr_ok && reg_wr_data[9] && !reg_wr_data[15] |-> ##2 negotiation_restart)
    else $error("restart pulse missing");
  a_soft_reset_held: assert property (
    wr_ok && reg_wr_data[15] |=> soft_reset_request [*8]) else $error("soft reset short");
  a_soft_reset_length: assert property (
    $fell(soft_reset_request) |-> $past(soft_reset_request, 26)
      && !$past(soft_reset_request, 27)) else $error("soft reset length wrong");
  a_read_valid_timing: assert property (
    reg_rd_valid == $past(reg_rd_en)) else $error("read valid timing wrong");
  a_unmapped_reads_zero: assert property (
    reg_rd_en && reg_addr != phy_ctrl_pkg::CTRL_ADDR |=> reg_rd_data == phy_ctrl_pkg::READ_ZERO)
    else $error("unmapped read not zero");
  a_one_way_zero: assert property (
    one_way_transmit_enable == 1'b0) else $error("one way enable set");
  a_tx_needs_link: assert property (
    mac_tx_allow |-> $past(link_valid && !mac_isolate && !soft_power_down && !soft_reset_request))
    else $error("transmit allowed without link");
  a_neg_enable_write: assert property (
    wr_ok |=> negotiation_enable == $past(reg_wr_data[12])) else $error("negotiation enable wrong");
  a_speed_follows_write: assert property (
    wr_ok && {reg_wr_data[6], reg_wr_data[13]} != 2'h3
      |=> speed_select == $past({reg_wr_data[6], reg_wr_data[13]})) else $error("speed wrong");
  a_speed_keeps_reserved: assert property (
    wr_ok && {reg_wr_data[6], reg_wr_data[13]} == 2'h3 |=> $stable(speed_select))
    else $error("reserved speed taken");
endmodule : phy_ctrl_sva
bind phy_basic_control_register phy_ctrl_sva phy_ctrl_sva_inst (.*);
`default_nettype wire

// >>> verilog/control_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Signals that pass between the register core, strap capture and reset sequencer.
interface control_link_if;
  // Strap defaults after synchronisation, and a pulse that loads them.
  logic [1:0] strap_speed;
  logic strap_neg_enable;
  logic strap_power_down;
  logic strap_load;
  // Software reset start request and its completion pulse.
  logic reset_start;
  logic reset_done;

  // Strap capture drives the strap group.
  modport strap_side (output strap_speed, output strap_neg_enable,
                      output strap_power_down, output strap_load);
  // The sequencer answers start with done.
  modport seq_side (input reset_start, output reset_done);
  // The register core consumes both.
  modport core_side (input strap_speed, input strap_neg_enable,
                     input strap_power_down, input strap_load,
                     output reset_start, input reset_done);
endinterface : control_link_if
`default_nettype wire

// >>> verilog/phy_basic_control_register.sv
// Summary of operation
// - Bit 15 resets core, clears when done.
// - Bit 14 enables loopback, resets to zero.
// - Speed code bits 6 and 13 select rate.
// - Reset defaults follow configuration strap pins.
// - Bit 12 enables negotiation, default one.
// - Bit 11 selects software power-down.
// - Bit 10 isolates all MAC-side pins.
// - Bit 9 restarts negotiation, self clearing.
// - Bit 7 enables collision signal test.
// - Bit 5 reads zero; transmit needs link.
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_register (
  // Clock and synchronous active-low hardware reset.
  input wire logic clk,
  input wire logic resetn,
  // Management register port, one access per strobe.
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  // Hardware configuration pins.
  input wire logic [1:0] strap_speed_pin,
  input wire logic strap_neg_enable_pin,
  input wire logic strap_power_down_pin,
  // Link state from the core, same clock.
  input wire logic link_valid,
  // Controls towards the transceiver core.
  output logic soft_reset_request,
  output logic loopback_enable,
  output logic [1:0] speed_select,
  output logic negotiation_enable,
  output logic soft_power_down,
  output logic mac_isolate,
  output logic mac_pin_oe_n,
  output logic negotiation_restart,
  output logic full_duplex_select,
  output logic collision_signal_test,
  output logic one_way_transmit_enable,
  output logic mac_tx_allow
);

  // Link between this core and its two helpers.
  control_link_if link ();

  // Control fields; each is its own flip-flop so outputs come straight from them.
  logic soft_reset_reg;
  logic loopback_reg;
  logic [1:0] speed_reg;
  logic neg_enable_reg;
  logic power_down_reg;
  logic isolate_reg;
  logic restart_reg;
  logic restart_pulse_reg;
  logic duplex_reg;
  logic collision_signal_test_reg;
  logic pin_oe_n_reg;
  logic tx_allow_reg;
  logic one_way_reg; // Always zero; no one-way mode is offered.
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;

  // Decoded accesses and the loaded defaults.
  logic wr_hit; // A write to the control word that is accepted.
  logic rd_hit; // The address matches the control word; the read strobe gates it where it is used.
  logic load_defaults; // Hardware strap load or end of a software reset.
  logic [15:0] ctrl_value; // The word as software sees it.

  // Strap pins pass through a synchroniser before they are used.
  // Their load arrives four edges after release and overrides any earlier write except a soft reset started by bit 15.
  strap_capture u_strap (
    .clk(clk),
    .resetn(resetn),
    .strap_speed_pin(strap_speed_pin),
    .strap_neg_enable_pin(strap_neg_enable_pin),
    .strap_power_down_pin(strap_power_down_pin),
    .link(link)
  );

  // The sequencer decides how long a software reset lasts.
  // A start while it is busy is refused there, so one write gives one reset.
  soft_reset_sequencer u_seq (
    .clk(clk),
    .resetn(resetn),
    .link(link)
  );

  // Address decode shared by the read and write paths.
  function automatic logic is_ctrl_addr(input logic [4:0] addr);
    is_ctrl_addr = addr == phy_ctrl_pkg::CTRL_ADDR;
  endfunction : is_ctrl_addr

  // Writes are ignored while a software reset runs, since the core is not live.
  // Such writes are dropped, not queued; software polls bit 15 before writing again.
  assign wr_hit = reg_wr_en && is_ctrl_addr(reg_addr) && !soft_reset_reg;
  assign rd_hit = is_ctrl_addr(reg_addr);

  // A software reset reloads the same defaults that hardware reset gives.
  // The strap load and the end of a software reset never fall in one cycle.
  assign load_defaults = link.strap_load || link.reset_done;

  // Start the sequencer on a write of one to the reset bit.
  assign link.reset_start = wr_hit && reg_wr_data[phy_ctrl_pkg::SOFT_RESET_BIT];

  // Assemble the readable word; bit 5 and bits 4 to 0 always read zero.
  // Reserved bits are forced here so that no field flop can leak into them.
  always_comb
  begin
    ctrl_value = phy_ctrl_pkg::READ_ZERO;
    ctrl_value[phy_ctrl_pkg::SOFT_RESET_BIT] = soft_reset_reg;
    ctrl_value[phy_ctrl_pkg::LOOPBACK_BIT] = loopback_reg;
    ctrl_value[phy_ctrl_pkg::SPEED_HIGH_BIT] = speed_reg[1];
    ctrl_value[phy_ctrl_pkg::SPEED_LOW_BIT] = speed_reg[0];
    ctrl_value[phy_ctrl_pkg::NEG_ENABLE_BIT] = neg_enable_reg;
    ctrl_value[phy_ctrl_pkg::POWER_DOWN_BIT] = power_down_reg;
    ctrl_value[phy_ctrl_pkg::ISOLATE_BIT] = isolate_reg;
    ctrl_value[phy_ctrl_pkg::NEG_RESTART_BIT] = restart_reg;
    ctrl_value[phy_ctrl_pkg::DUPLEX_BIT] = duplex_reg;
    ctrl_value[phy_ctrl_pkg::COLLISION_SIGNAL_TEST_BIT] = collision_signal_test_reg;
    ctrl_value[phy_ctrl_pkg::ONE_WAY_BIT] = 1'b0;
  end

  // Soft reset bit: set by the write, held for the whole reset, cleared by done.
  // The sequencer owns the timing, so this bit only mirrors its start and done.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      soft_reset_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (link.reset_start)
      soft_reset_reg <= 1'b1;
    else if (link.reset_done)
      soft_reset_reg <= 1'b0;
  end

  // Loopback select.
  // A strap load or the end of a software reset returns it to off.
  always_ff @(posedge clk)
  begin
    if (!resetn || load_defaults)
      loopback_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (wr_hit)
      loopback_reg <= reg_wr_data[phy_ctrl_pkg::LOOPBACK_BIT];
  end

  // Speed select; a written reserved code is refused, but a strap load takes whatever code the pins give.
  // A write of the reserved code still writes every other field of the word.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      speed_reg <= phy_ctrl_pkg::SPEED_RESET;
    else if (load_defaults)
      speed_reg <= link.strap_speed;
    else if (wr_hit && phy_ctrl_pkg::speed_field(reg_wr_data) != phy_ctrl_pkg::SPEED_RESERVED)
      speed_reg <= phy_ctrl_pkg::speed_field(reg_wr_data);
  end

  // Negotiation enable; defaults to on, overridden by the strap.
  // A strap that disables it lets an unmanaged system force a fixed rate.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      neg_enable_reg <= phy_ctrl_pkg::NEG_ENABLE_RESET;
    else if (load_defaults)
      neg_enable_reg <= link.strap_neg_enable;
    else if (wr_hit)
      neg_enable_reg <= reg_wr_data[phy_ctrl_pkg::NEG_ENABLE_BIT];
  end

  // Software power-down; a strap may hold the part down until software clears it.
  // Writes still land while powered down, so software can wake the part.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      power_down_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (load_defaults)
      power_down_reg <= link.strap_power_down;
    else if (wr_hit)
      power_down_reg <= reg_wr_data[phy_ctrl_pkg::POWER_DOWN_BIT];
  end

  // Isolate select.
  // The output enable flop below carries the same value to the pin drivers.
  always_ff @(posedge clk)
  begin
    if (!resetn || load_defaults)
      isolate_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (wr_hit)
      isolate_reg <= reg_wr_data[phy_ctrl_pkg::ISOLATE_BIT];
  end

  // MAC pin output enable, low while the pins are driven; it follows isolate
  // even mid-frame, which is the point of isolation.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      pin_oe_n_reg <= 1'b0;
    else if (load_defaults)
      pin_oe_n_reg <= 1'b0;
    else if (wr_hit)
      pin_oe_n_reg <= reg_wr_data[phy_ctrl_pkg::ISOLATE_BIT];
  end

  // Restart bit: a new write wins over the self clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!resetn || load_defaults)
      restart_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (wr_hit && reg_wr_data[phy_ctrl_pkg::NEG_RESTART_BIT])
      restart_reg <= 1'b1;
    else if (restart_pulse_reg)
      restart_reg <= 1'b0;
  end

  // One restart pulse per request; the bit clears the cycle after it.
  // A second request before the pulse merges into it; one in the pulse cycle itself gives a second pulse.
  always_ff @(posedge clk)
  begin
    if (!resetn || load_defaults)
      restart_pulse_reg <= 1'b0;
    else
      restart_pulse_reg <= restart_reg && !restart_pulse_reg;
  end

  // Duplex select.
  // Half duplex is the default after any reset.
  always_ff @(posedge clk)
  begin
    if (!resetn || load_defaults)
      duplex_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (wr_hit)
      duplex_reg <= reg_wr_data[phy_ctrl_pkg::DUPLEX_BIT];
  end

  // Collision test enable.
  // Cleared by every reset so a test never survives a restart of the core.
  always_ff @(posedge clk)
  begin
    if (!resetn || load_defaults)
      collision_signal_test_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else if (wr_hit)
      collision_signal_test_reg <= reg_wr_data[phy_ctrl_pkg::COLLISION_SIGNAL_TEST_BIT];
  end

  // Transmit gate: only with a valid link, and never while isolated, down or in reset.
  // It lags link_valid by one cycle; the core must not rely on it sooner.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      tx_allow_reg <= 1'b0;
    else
      tx_allow_reg <= link_valid && !isolate_reg && !power_down_reg && !soft_reset_reg;
  end

  // One-way transmit is not offered, so this flop only ever holds zero.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      one_way_reg <= phy_ctrl_pkg::FIELD_CLEAR;
    else
      one_way_reg <= phy_ctrl_pkg::FIELD_CLEAR;
  end

  // Read port: data one cycle after the strobe, held until the next read.
  // Unmapped addresses read zero so software never sees stale data.
  // A read in the same cycle as a write returns the value before the write.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rd_data_reg <= phy_ctrl_pkg::READ_ZERO;
    else if (reg_rd_en)
      rd_data_reg <= rd_hit ? ctrl_value : phy_ctrl_pkg::READ_ZERO;
  end

  // Read valid pulse.
  // It pulses for every strobe, mapped or not, so the host never waits in vain.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rd_valid_reg <= 1'b0;
    else
      rd_valid_reg <= reg_rd_en;
  end

  // Outputs come straight from the flip-flops above.
  // The pulse, not the register bit, drives the restart output.
  assign reg_rd_data = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign soft_reset_request = soft_reset_reg;
  assign loopback_enable = loopback_reg;
  assign speed_select = speed_reg;
  assign negotiation_enable = neg_enable_reg;
  assign soft_power_down = power_down_reg;
  assign mac_isolate = isolate_reg;
  assign mac_pin_oe_n = pin_oe_n_reg;
  assign negotiation_restart = restart_pulse_reg;
  assign full_duplex_select = duplex_reg;
  assign collision_signal_test = collision_signal_test_reg;
  assign one_way_transmit_enable = one_way_reg;
  assign mac_tx_allow = tx_allow_reg;

endmodule : phy_basic_control_register
`default_nettype wire

// >>> verilog/phy_ctrl_pkg.sv
`default_nettype none
// Shared constants and types for the basic control register block.
package phy_ctrl_pkg;

  // Register address and width of the management register port.
  localparam logic [4:0] CTRL_ADDR = 5'h00;
  localparam logic [15:0] CTRL_RESET_VALUE = 16'h1040;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Field positions inside the control word.
  localparam int SOFT_RESET_BIT = 15;
  localparam int LOOPBACK_BIT = 14;
  localparam int SPEED_LOW_BIT = 13;
  localparam int NEG_ENABLE_BIT = 12;
  localparam int POWER_DOWN_BIT = 11;
  localparam int ISOLATE_BIT = 10;
  localparam int NEG_RESTART_BIT = 9;
  localparam int DUPLEX_BIT = 8;
  localparam int COLLISION_SIGNAL_TEST_BIT = 7;
  localparam int SPEED_HIGH_BIT = 6;
  localparam int ONE_WAY_BIT = 5;

  // Speed codes, high bit first.
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_RESERVED = 2'h3;

  // Values taken by each field after hardware reset, before straps load.
  localparam logic [1:0] SPEED_RESET = 2'h2;
  localparam logic NEG_ENABLE_RESET = 1'h1;
  localparam logic FIELD_CLEAR = 1'h0;

  // Timing: clock rate and how long a software reset holds the core.
  localparam int CLK_MHZ = 25;
  localparam int SOFT_RESET_TIME_NS = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SOFT_RESET_LAST = 8'(SOFT_RESET_CYCLES - 1);
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [1:0] STRAP_SETTLE_LAST = 2'h2;
  localparam logic [1:0] SETTLE_ZERO = 2'h0;

  // Software reset sequencer states.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD} seq_state_t;

  // Extracts the two-bit speed code from a control word.
  function automatic logic [1:0] speed_field(input logic [15:0] word);
    speed_field = {word[SPEED_HIGH_BIT], word[SPEED_LOW_BIT]};
  endfunction : speed_field

endpackage : phy_ctrl_pkg
`default_nettype wire

// >>> verilog/soft_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Times a software reset of the core and reports its completion.
module soft_reset_sequencer (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Start and done towards the register core.
  control_link_if.seq_side link
);

  phy_ctrl_pkg::seq_state_t state_reg; // Idle or holding the core in reset.
  logic [7:0] count_reg; // Cycles spent holding.
  logic done_reg; // One-cycle completion pulse.

  // Holds for a fixed count, then pulses done; a start while busy is ignored.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= phy_ctrl_pkg::SEQ_IDLE;
      count_reg <= phy_ctrl_pkg::COUNT_ZERO;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        phy_ctrl_pkg::SEQ_IDLE:
        begin
          count_reg <= phy_ctrl_pkg::COUNT_ZERO;
          if (link.reset_start)
            state_reg <= phy_ctrl_pkg::SEQ_HOLD;
        end
        phy_ctrl_pkg::SEQ_HOLD:
        begin
          if (count_reg == phy_ctrl_pkg::SOFT_RESET_LAST)
          begin
            done_reg <= 1'b1;
            state_reg <= phy_ctrl_pkg::SEQ_IDLE;
          end
          else
            count_reg <= count_reg + 8'h01;
        end
        default:
          state_reg <= phy_ctrl_pkg::SEQ_IDLE;
      endcase
    end
  end

  assign link.reset_done = done_reg;

endmodule : soft_reset_sequencer
`default_nettype wire

// >>> verilog/strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronises the configuration pins and pulses a load once they have settled.
module strap_capture (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Raw configuration pins.
  input wire logic [1:0] strap_speed_pin,
  input wire logic strap_neg_enable_pin,
  input wire logic strap_power_down_pin,
  // Towards the register core.
  control_link_if.strap_side link
);

  logic [3:0] meta_reg; // First stage, read only by the second stage.
  logic [3:0] sync_reg; // Second stage, safe for logic.
  logic [1:0] settle_reg; // Counts cycles after reset release.
  logic load_reg; // One-cycle load pulse.
  logic loaded_reg; // Set once the load has been issued.

  // Two-flop synchroniser; the pins may change at any time.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= {strap_speed_pin, strap_neg_enable_pin, strap_power_down_pin};
      sync_reg <= meta_reg;
    end
  end

  // Waits for the synchroniser to fill after release, then loads once.
  // Reading the pins only after release keeps reset a pure constant load.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      settle_reg <= phy_ctrl_pkg::SETTLE_ZERO;
      load_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end
    else if (!loaded_reg && settle_reg == phy_ctrl_pkg::STRAP_SETTLE_LAST)
    begin
      load_reg <= 1'b1;
      loaded_reg <= 1'b1;
    end
    else
    begin
      settle_reg <= loaded_reg ? settle_reg : settle_reg + 2'h1;
      load_reg <= 1'b0;
    end
  end

  assign link.strap_speed = sync_reg[3:2];
  assign link.strap_neg_enable = sync_reg[1];
  assign link.strap_power_down = sync_reg[0];
  assign link.strap_load = load_reg;

endmodule : strap_capture
`default_nettype wire
